// File: src/sacc_pkg.sv
// Package of constants and types for the converter control block.
`default_nettype none
package sacc_pkg;
	// Channel select codes.
	localparam logic [4:0] CH_PIN_LO_FIRST  = 5'h00;
	localparam logic [4:0] CH_PIN_LO_LAST   = 5'h03;
	localparam logic [4:0] CH_PIN_HI_FIRST  = 5'h08;
	localparam logic [4:0] CH_PIN_HI_LAST   = 5'h0B;
	localparam logic [4:0] CH_RSVD_A_FIRST  = 5'h16;
	localparam logic [4:0] CH_RSVD_A_LAST   = 5'h19;
	localparam logic [4:0] CH_TEMP          = 5'h1A;
	localparam logic [4:0] CH_BANDGAP       = 5'h1B;
	localparam logic [4:0] CH_RSVD_B        = 5'h1C;
	localparam logic [4:0] CH_REF_HIGH      = 5'h1D;
	localparam logic [4:0] CH_REF_LOW       = 5'h1E;
	localparam logic [4:0] CH_OFF           = 5'h1F;
	// Analog mux source encodings sent to the converter core.
	localparam logic [2:0] SRC_PIN          = 3'h0;
	localparam logic [2:0] SRC_REF_LOW      = 3'h1;
	localparam logic [2:0] SRC_REF_HIGH     = 3'h2;
	localparam logic [2:0] SRC_TEMP         = 3'h3;
	localparam logic [2:0] SRC_BANDGAP      = 3'h4;
	localparam logic [2:0] SRC_RESERVED     = 3'h5;
	localparam logic [2:0] SRC_NONE         = 3'h6;
	// Clock source select codes.
	localparam logic [1:0] CLK_BUS          = 2'h0;
	localparam logic [1:0] CLK_BUS_HALF     = 2'h1;
	localparam logic [1:0] CLK_ALT          = 2'h2;
	localparam logic [1:0] CLK_ASYNC        = 2'h3;
	// Widths, step and sample counts, and reset values.
	localparam int         RESULT_W         = 10;
	localparam int         DIV_W            = 2;
	localparam int         SAR_STEPS        = 10;
	localparam int         SAMPLE_SHORT     = 4;
	localparam int         SAMPLE_LONG      = 24;
	localparam logic [4:0] CH_RESET         = 5'h1F;
	localparam logic [9:0] RESULT_RESET     = 10'h000;
	// Conversion sequencer states.
	typedef enum logic [1:0] {
		SACC_IDLE,
		SACC_SAMPLE,
		SACC_CONVERT
	} sacc_state_t;
endpackage : sacc_pkg
`default_nettype wire

// File: src/sacc_tick.sv
// Conversion clock enable generator: source choice and power-of-two divide.
`default_nettype none
module sacc_tick (
	input  wire logic       core_clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       clk_en_i,
	input  wire logic [1:0] clk_src_i,
	input  wire logic [1:0] div_sel_i,
	input  wire logic       alt_tick_i,
	input  wire logic       async_tick_i,
	input  wire logic       deep_stop_i,
	output logic            tick_o
);
	logic       half_q;
	logic       src_tick;
	logic [2:0] div_cnt_q;
	logic [2:0] div_max;

	// Pick the source pulse; the alternate clock is dead in deep stop.
	always_comb begin
		case (clk_src_i)
			sacc_pkg::CLK_BUS:      src_tick = 1'b1; // R06
			sacc_pkg::CLK_BUS_HALF: src_tick = half_q; // R06
			sacc_pkg::CLK_ALT:      src_tick = alt_tick_i & ~deep_stop_i; // R06 R08
			default:                src_tick = async_tick_i; // R06
		endcase
		div_max = 3'((1 << div_sel_i) - 1);
	end

	// Bus clock halver.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			half_q <= 1'b0;
		end else if (clk_en_i) begin
			half_q <= ~half_q;
		end
	end

	// Divide by 1, 2, 4 or 8 of the chosen source.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			div_cnt_q <= 3'h0;
			tick_o    <= 1'b0;
		end else if (clk_en_i) begin
			tick_o <= 1'b0;
			if (src_tick) begin
				if (div_cnt_q >= div_max) begin
					div_cnt_q <= 3'h0;
					tick_o    <= 1'b1; // R07
				end else begin
					div_cnt_q <= div_cnt_q + 3'h1;
				end
			end
		end
	end
endmodule // sacc_tick
`default_nettype wire

// File: src/sacc_ctrl.sv
// Control logic for a 10-bit successive-approximation converter.
// What the document requires of this block and of software
// R01 - Unimplemented channel codes route to low reference; 11101 high, 11110 low reference.
// R02 - Reserved codes are accepted; their result is undefined.
// R03 - Codes 0-3 and 8-11 select pins, each with its own pin enable bit.
// R04 - Code 11010 selects temperature sensor, 11011 the bandgap.
// R05 - Software sets the bandgap buffer enable before choosing the bandgap channel.
// R06 - Conversion clock comes from bus, bus half, local async or alternate clock.
// R07 - Selected source is divided by the divide field to form the conversion clock.
// R08 - Alternate clock works in wait mode, not in deep stop mode.
// R09 - With hardware trigger enabled, each counter overflow starts a conversion; the code starts one only from idle and ignores overflows during a conversion.
// R10 - Software sets both low-voltage enables before deep stop operation.
// R11 - Results are right-justified, 10-bit or 8-bit by resolution mode.
// R12 - Single and continuous conversion; single returns to idle by itself.
// R13 - Automatic compare flags less-than or greater-or-equal match, may interrupt.
// R14 - Conversion done flag with a software-enabled interrupt request.
// R15 - Sample time and speed-versus-power are software configurable.
// R16 - Only two pin enable registers exist.
// R17 - Converter keeps working in wait and deep stop modes.
// R18 - All-ones channel select powers down, isolates input, ends continuous mode.
// R19 - Status-control write aborts conversion and restarts unless channel is all ones.
// R20 - Done flag clears on status-control write or low result read.
// R21 - Hardware trigger is synchronised and yields one start per overflow.
`default_nettype none
module sacc_ctrl (
	input  wire logic        core_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        clk_en_i,
	// Software side.
	input  wire logic        sc1_wr_i,
	input  wire logic [4:0]  channel_select_i,
	input  wire logic        continuous_conversion_enable_i,
	input  wire logic        done_irq_enable_i,
	input  wire logic        result_low_rd_i,
	input  wire logic        hw_trig_enable_i,
	input  wire logic        compare_enable_i,
	input  wire logic        compare_gte_i,
	input  wire logic [9:0]  compare_value_i,
	input  wire logic        mode_8bit_i,
	input  wire logic        long_sample_i,
	input  wire logic        low_power_i,
	input  wire logic [1:0]  clk_src_i,
	input  wire logic [1:0]  clock_divide_select_i,
	input  wire logic [7:0]  analog_pin_ctrl_one_i,
	input  wire logic [7:0]  analog_pin_ctrl_two_i,
	input  wire logic        wait_mode_i,
	input  wire logic        deep_stop_mode_i,
	// Asynchronous inputs from pins or other clocks.
	input  wire logic        hw_trigger_input_i,
	input  wire logic        local_async_conv_clock_i,
	input  wire logic        alternate_clock_input_i,
	// Converter core side.
	input  wire logic        cmp_bit_i,
	output logic [2:0]       mux_src_o,
	output logic [3:0]       pin_index_o,
	output logic             pin_enable_o,
	output logic             conv_power_o,
	output logic             sample_o,
	output logic             low_power_o,
	output logic [9:0]       trial_o,
	// Status.
	output logic [9:0]       result_o,
	output logic             conversion_done_flag_o,
	output logic             irq_o,
	output logic             active_o
);
	sacc_pkg::sacc_state_t state_q;
	logic [2:0]  trig_sync_q;
	logic [2:0]  async_sync_q;
	logic [2:0]  alt_sync_q;
	logic        trig_evt;
	logic        tick;
	logic        ch_off;
	logic [2:0]  mux_d;
	logic [4:0]  samp_cnt_q;
	logic [3:0]  bit_cnt_q;
	logic [9:0]  sar_q;
	logic [9:0]  fin;
	logic [9:0]  cmp_ref;
	logic        cmp_ok;
	logic [15:0] pin_en_all;

	assign ch_off     = (channel_select_i == sacc_pkg::CH_OFF); // R18
	assign pin_en_all = {analog_pin_ctrl_two_i, analog_pin_ctrl_one_i}; // R16

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Two flops before use; the third stage only feeds the edge detector.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			trig_sync_q  <= 3'h0;
			async_sync_q <= 3'h0;
			alt_sync_q   <= 3'h0;
		end else if (clk_en_i) begin
			trig_sync_q  <= {trig_sync_q[1:0], hw_trigger_input_i}; // R21
			async_sync_q <= {async_sync_q[1:0], local_async_conv_clock_i};
			alt_sync_q   <= {alt_sync_q[1:0], alternate_clock_input_i};
		end
	end
	// Only a rising edge counts, so a long overflow pulse starts one conversion.
	assign trig_evt = trig_sync_q[1] & ~trig_sync_q[2]; // R21 R09

	sacc_tick u_tick (
		.core_clk_i   (core_clk_i),
		.rst_b_i      (rst_b_i),
		.clk_en_i     (clk_en_i),
		.clk_src_i    (clk_src_i),
		.div_sel_i    (clock_divide_select_i),
		.alt_tick_i   (alt_sync_q[1] & ~alt_sync_q[2]),
		.async_tick_i (async_sync_q[1] & ~async_sync_q[2]),
		.deep_stop_i  (deep_stop_mode_i),
		.tick_o       (tick)
	);

	// ----------------------------------------------------------------
	// Channel decode
	// ----------------------------------------------------------------
	always_comb begin
		case (channel_select_i)
			sacc_pkg::CH_TEMP:     mux_d = sacc_pkg::SRC_TEMP; // R04
			sacc_pkg::CH_BANDGAP:  mux_d = sacc_pkg::SRC_BANDGAP; // R04
			sacc_pkg::CH_RSVD_B:   mux_d = sacc_pkg::SRC_RESERVED; // R02
			sacc_pkg::CH_REF_HIGH: mux_d = sacc_pkg::SRC_REF_HIGH; // R01
			sacc_pkg::CH_REF_LOW:  mux_d = sacc_pkg::SRC_REF_LOW; // R01
			sacc_pkg::CH_OFF:      mux_d = sacc_pkg::SRC_NONE; // R18
			default: begin
				if ((channel_select_i <= sacc_pkg::CH_PIN_LO_LAST) ||
				    (channel_select_i >= sacc_pkg::CH_PIN_HI_FIRST &&
				     channel_select_i <= sacc_pkg::CH_PIN_HI_LAST)) begin
					mux_d = sacc_pkg::SRC_PIN; // R03
				end else if (channel_select_i >= sacc_pkg::CH_RSVD_A_FIRST &&
				             channel_select_i <= sacc_pkg::CH_RSVD_A_LAST) begin
					mux_d = sacc_pkg::SRC_RESERVED; // R02
				end else begin
					mux_d = sacc_pkg::SRC_REF_LOW; // R01
				end
			end
		endcase
	end

	// Mux outputs registered; the pin enable bit follows only pin channels.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			mux_src_o    <= sacc_pkg::SRC_NONE;
			pin_index_o  <= 4'h0;
			pin_enable_o <= 1'b0;
			low_power_o  <= 1'b0;
		end else if (clk_en_i) begin
			mux_src_o    <= mux_d;
			pin_index_o  <= channel_select_i[3:0];
			pin_enable_o <= (mux_d == sacc_pkg::SRC_PIN) &
			                pin_en_all[channel_select_i[3:0]]; // R03
			low_power_o  <= low_power_i; // R15
		end
	end

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	assign fin     = {sar_q[9:1], cmp_bit_i};
	assign cmp_ref = mode_8bit_i ? {2'b00, compare_value_i[7:0]} : compare_value_i;
	// The compare uses the value as it will be reported.
	always_comb begin
		if (mode_8bit_i) begin
			cmp_ok = compare_gte_i ? ({2'b00, fin[9:2]} >= cmp_ref) :
			                         ({2'b00, fin[9:2]} < cmp_ref); // R13
		end else begin
			cmp_ok = compare_gte_i ? (fin >= cmp_ref) : (fin < cmp_ref); // R13
		end
	end

	// Steps advance on conversion clock ticks; the sequencer keeps running
	// in wait and deep stop, except on the alternate clock in deep stop, which gives no ticks; clock enable low also freezes it.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			state_q      <= sacc_pkg::SACC_IDLE;
			samp_cnt_q   <= 5'h00;
			bit_cnt_q    <= 4'h0;
			sar_q        <= sacc_pkg::RESULT_RESET;
			conv_power_o <= 1'b0;
			sample_o     <= 1'b0;
			active_o     <= 1'b0;
			trial_o      <= sacc_pkg::RESULT_RESET;
		end else if (clk_en_i) begin
			if (sc1_wr_i) begin
				// Abort, then restart unless switched off.
				state_q      <= ch_off ? sacc_pkg::SACC_IDLE : sacc_pkg::SACC_SAMPLE; // R19
				conv_power_o <= ~ch_off; // R18
				sample_o     <= ~ch_off;
				active_o     <= ~ch_off;
				samp_cnt_q   <= 5'h00;
			end else if (ch_off) begin
				state_q      <= sacc_pkg::SACC_IDLE; // R18
				conv_power_o <= 1'b0;
				sample_o     <= 1'b0;
				active_o     <= 1'b0;
			end else begin
				case (state_q)
					sacc_pkg::SACC_IDLE: begin
						conv_power_o <= 1'b0;
						if (hw_trig_enable_i && trig_evt) begin
							state_q      <= sacc_pkg::SACC_SAMPLE; // R09
							conv_power_o <= 1'b1; // R17
							sample_o     <= 1'b1;
							active_o     <= 1'b1;
							samp_cnt_q   <= 5'h00;
						end
					end
					sacc_pkg::SACC_SAMPLE: begin
						if (tick) begin
							if (samp_cnt_q == 5'(long_sample_i ? sacc_pkg::SAMPLE_LONG - 1 :
							                     sacc_pkg::SAMPLE_SHORT - 1)) begin // R15
								state_q   <= sacc_pkg::SACC_CONVERT;
								sample_o  <= 1'b0;
								bit_cnt_q <= 4'(sacc_pkg::SAR_STEPS - 1);
								sar_q     <= 10'h200;
								trial_o   <= 10'h200;
							end else begin
								samp_cnt_q <= samp_cnt_q + 5'h01;
							end
						end
					end
					sacc_pkg::SACC_CONVERT: begin
						if (tick) begin
							if (bit_cnt_q == 4'h0) begin
								if (continuous_conversion_enable_i) begin
									state_q  <= sacc_pkg::SACC_SAMPLE; // R12
									sample_o <= 1'b1;
								end else begin
									state_q      <= sacc_pkg::SACC_IDLE; // R12
									conv_power_o <= 1'b0;
									active_o     <= 1'b0;
								end
								samp_cnt_q <= 5'h00;
							end else begin
								// Keep the tried bit if the comparator says so, try the next.
								sar_q <= (sar_q & ~(10'h001 << bit_cnt_q)) |
								         ({9'h000, cmp_bit_i} << bit_cnt_q) |
								         (10'h001 << (bit_cnt_q - 4'h1));
								trial_o <= (sar_q & ~(10'h001 << bit_cnt_q)) |
								           ({9'h000, cmp_bit_i} << bit_cnt_q) |
								           (10'h001 << (bit_cnt_q - 4'h1));
								bit_cnt_q <= bit_cnt_q - 4'h1;
							end
						end
					end
					default: state_q <= sacc_pkg::SACC_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Result, done flag and interrupt
	// ----------------------------------------------------------------
	// Set wins over clear so a completion coinciding with a read is kept.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			result_o               <= sacc_pkg::RESULT_RESET;
			conversion_done_flag_o <= 1'b0;
			irq_o                  <= 1'b0;
		end else if (clk_en_i) begin
			if (state_q == sacc_pkg::SACC_CONVERT && tick && bit_cnt_q == 4'h0 &&
			    !sc1_wr_i && !ch_off && (!compare_enable_i || cmp_ok)) begin
				result_o <= mode_8bit_i ? {2'b00, fin[9:2]} : fin; // R11
				conversion_done_flag_o <= 1'b1; // R14 R13
				irq_o                  <= done_irq_enable_i; // R14
			end else if (sc1_wr_i || result_low_rd_i) begin
				conversion_done_flag_o <= 1'b0; // R20
				irq_o                  <= 1'b0;
			end else begin
				irq_o <= conversion_done_flag_o & done_irq_enable_i; // R14
			end
		end
	end
	// Wait mode needs no special handling: all sources keep ticking.
	logic unused_ok;
	assign unused_ok = wait_mode_i; // R08
endmodule // sacc_ctrl
`default_nettype wire

// File: test/sacc_core_model.sv
// Behavioural converter core: one analog level per source (one per pin for pins) and the comparator.
`default_nettype none
module sacc_core_model (
	input  wire logic       core_clk_i,
	input  wire logic [2:0] mux_src_i,
	input  wire logic [3:0] pin_index_i,
	input  wire logic       conv_power_i,
	input  wire logic [9:0] trial_i,
	output logic            cmp_bit_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] level;
	logic       idle_q = 1'b0;
	// Distinct levels except low reference and none, which both give zero, so that a wrong source choice shows up in the result.
	always_comb begin
		case (mux_src_i)
			sacc_pkg::SRC_PIN:      level = 10'h100 + {2'b00, pin_index_i, 4'h0};
			sacc_pkg::SRC_REF_HIGH: level = 10'h3FF;
			sacc_pkg::SRC_TEMP:     level = 10'h2C0;
			sacc_pkg::SRC_BANDGAP:  level = 10'h0C0;
			sacc_pkg::SRC_RESERVED: level = 10'h2AA;
			default:                level = 10'h000;
		endcase
	end
	// An unpowered core gives no real decision; it toggles so a stale bit is never trusted.
	always @(posedge core_clk_i) begin
		idle_q <= ~idle_q;
	end
	assign cmp_bit_o = conv_power_i ? (trial_i <= level) : idle_q;
endmodule // sacc_core_model
`default_nettype wire

// File: test/sacc_ctrl_assertions.sv
// Concurrent checks on the ports of the converter control block.
`default_nettype none
module sacc_ctrl_assertions (
	input wire logic       core_clk_i,
	input wire logic       rst_b_i,
	input wire logic       clk_en_i,
	input wire logic       sc1_wr_i,
	input wire logic [4:0] channel_select_i,
	input wire logic       continuous_conversion_enable_i,
	input wire logic       mode_8bit_i,
	input wire logic [1:0] clk_src_i,
	input wire logic       deep_stop_mode_i,
	input wire logic [7:0] analog_pin_ctrl_one_i,
	input wire logic [7:0] analog_pin_ctrl_two_i,
	input wire logic [2:0] mux_src_o,
	input wire logic [3:0] pin_index_o,
	input wire logic       pin_enable_o,
	input wire logic       conv_power_o,
	input wire logic       sample_o,
	input wire logic [9:0] trial_o,
	input wire logic [9:0] result_o,
	input wire logic       conversion_done_flag_o,
	input wire logic       active_o
);
	// Source that a channel code must reach; unlisted codes fall to the low reference.
	function automatic logic [2:0] exp_src(input logic [4:0] c);
		if (c[4:2] == 3'b000 || c[4:2] == 3'b010) return sacc_pkg::SRC_PIN;
		case (c)
			5'h16, 5'h17, 5'h18, 5'h19, 5'h1C: return sacc_pkg::SRC_RESERVED;
			5'h1A: return sacc_pkg::SRC_TEMP;
			5'h1B: return sacc_pkg::SRC_BANDGAP;
			5'h1D: return sacc_pkg::SRC_REF_HIGH;
			default: return sacc_pkg::SRC_REF_LOW;
		endcase
	endfunction
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	a_off_stays_idle:
	assert property (sc1_wr_i && clk_en_i && channel_select_i == 5'h1F |=> !active_o && !conv_power_o)
		else $error("channel off started a conversion");
	a_write_starts:
	assert property (sc1_wr_i && clk_en_i && channel_select_i != 5'h1F |=> active_o && sample_o)
		else $error("write did not start a conversion");
	a_write_clears_done:
	assert property (sc1_wr_i && clk_en_i |=> !conversion_done_flag_o)
		else $error("done flag survived a write");
	a_mux_decode:
	assert property (active_o && channel_select_i == $past(channel_select_i, 2)
		|-> mux_src_o == exp_src(channel_select_i)) else $error("wrong input source");
	a_pin_enable_bit:
	assert property (active_o && mux_src_o == sacc_pkg::SRC_PIN |-> pin_index_o
		== channel_select_i[3:0] && pin_enable_o == (channel_select_i[3] ?
		analog_pin_ctrl_two_i[channel_select_i[2:0]] :
		analog_pin_ctrl_one_i[channel_select_i[2:0]])) else $error("wrong pin enable");
	a_single_goes_idle:
	assert property ($rose(conversion_done_flag_o) && !continuous_conversion_enable_i |-> !active_o)
		else $error("single conversion stayed active");
	a_result_8bit:
	assert property ($rose(conversion_done_flag_o) && mode_8bit_i |-> result_o[9:8] == 2'b00)
		else $error("8-bit result not right-justified");
	a_alt_stop_frozen:
	assert property (active_o && clk_src_i == sacc_pkg::CLK_ALT && deep_stop_mode_i ##1
		deep_stop_mode_i && clk_src_i == sacc_pkg::CLK_ALT |-> $stable(trial_o) && $stable(sample_o))
		else $error("alternate clock ran in deep stop");
	a_power_active:
	assert property (active_o |-> conv_power_o) else $error("converter unpowered while active");
	c_continuous: cover property ($rose(conversion_done_flag_o) && continuous_conversion_enable_i);
	c_pin: cover property (active_o && mux_src_o == sacc_pkg::SRC_PIN);
	c_stop: cover property (active_o && deep_stop_mode_i && clk_src_i == sacc_pkg::CLK_ALT);
endmodule // sacc_ctrl_assertions
bind sacc_ctrl sacc_ctrl_assertions u_chk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
	.clk_en_i(clk_en_i), .sc1_wr_i(sc1_wr_i), .channel_select_i(channel_select_i),
	.continuous_conversion_enable_i(continuous_conversion_enable_i), .mode_8bit_i(mode_8bit_i),
	.clk_src_i(clk_src_i), .deep_stop_mode_i(deep_stop_mode_i),
	.analog_pin_ctrl_one_i(analog_pin_ctrl_one_i), .analog_pin_ctrl_two_i(analog_pin_ctrl_two_i),
	.mux_src_o(mux_src_o), .pin_index_o(pin_index_o), .pin_enable_o(pin_enable_o),
	.conv_power_o(conv_power_o), .sample_o(sample_o), .trial_o(trial_o), .result_o(result_o),
	.conversion_done_flag_o(conversion_done_flag_o), .active_o(active_o));
`default_nettype wire

// File: test/test_sacc_ctrl.sv
// Self-checking bench for the converter control block with a core model.
`default_nettype none
module test_sacc_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [4:0] c; logic [9:0] r; logic k;} sacc_row_t;
	logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, cont = 1'b0, irqen = 1'b0, rd = 1'b0, hwen = 1'b0;
	logic cen = 1'b0, gte = 1'b0, m8 = 1'b0, lsmp = 1'b0, lp = 1'b0, ws = 1'b0, ds = 1'b0;
	logic trig = 1'b0, lac = 1'b0, alt = 1'b0, cmp, pen, pwr, smp, lpo, done, irq, act, ok;
	logic [4:0] ch = 5'h1F;
	logic [9:0] cv = 10'h000, trial, res;
	logic [1:0] src = 2'h0, dv = 2'h0;
	logic [2:0] mux;
	logic [3:0] pidx;
	logic [7:0] ac = 8'h00;
	int         error_cnt = 0, checked = 0;
	int         cyc = 0, p = 0, n = 0;
	logic       ce = 1'b1;
	// Channel code, expected 10-bit result, and whether the result is defined.
	sacc_row_t rows [15] = '{'{5'h00, 10'h100, 1'b1}, '{5'h03, 10'h130, 1'b1},
		'{5'h08, 10'h180, 1'b1}, '{5'h0B, 10'h1B0, 1'b1}, '{5'h04, 10'h000, 1'b1},
		'{5'h0F, 10'h000, 1'b1}, '{5'h10, 10'h000, 1'b1}, '{5'h15, 10'h000, 1'b1},
		'{5'h1A, 10'h2C0, 1'b1}, '{5'h1B, 10'h0C0, 1'b1}, '{5'h1D, 10'h3FF, 1'b1},
		'{5'h1E, 10'h000, 1'b1}, '{5'h16, 10'h000, 1'b0}, '{5'h19, 10'h000, 1'b0},
		'{5'h1C, 10'h000, 1'b0}};
	always #50 clk = ~clk;
	// Slow sources for the alternate and local clock paths.
	always @(posedge clk) begin
		ac <= ac + 8'h01;
		alt <= ac[0];
		lac <= ac[1];
	end
	sacc_ctrl uut (.core_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(ce), .sc1_wr_i(wr),
		.channel_select_i(ch), .continuous_conversion_enable_i(cont), .done_irq_enable_i(irqen),
		.result_low_rd_i(rd), .hw_trig_enable_i(hwen), .compare_enable_i(cen),
		.compare_gte_i(gte), .compare_value_i(cv), .mode_8bit_i(m8), .long_sample_i(lsmp),
		.low_power_i(lp), .clk_src_i(src), .clock_divide_select_i(dv),
		.analog_pin_ctrl_one_i(8'h05), .analog_pin_ctrl_two_i(8'h0A), .wait_mode_i(ws),
		.deep_stop_mode_i(ds), .hw_trigger_input_i(trig), .local_async_conv_clock_i(lac),
		.alternate_clock_input_i(alt), .cmp_bit_i(cmp), .mux_src_o(mux), .pin_index_o(pidx),
		.pin_enable_o(pen), .conv_power_o(pwr), .sample_o(smp), .low_power_o(lpo),
		.trial_o(trial), .result_o(res), .conversion_done_flag_o(done), .irq_o(irq),
		.active_o(act));
	sacc_core_model u_core (.core_clk_i(clk), .mux_src_i(mux), .pin_index_i(pidx),
		.conv_power_i(pwr), .trial_i(trial), .cmp_bit_o(cmp));
	task automatic complete_run();
		if (error_cnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic c, input string m);
		checked++;
		if (c !== 1'b1) begin
			error_cnt++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic start(input logic [4:0] c);
		@(posedge clk);
		ch <= c;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic pulse_rd();
		@(posedge clk);
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	// Waits a bounded time for the done flag; ok tells whether it came.
	// The count of waited cycles is kept in cyc for rate checks.
	task automatic wait_done(input int lim);
		ok = 1'b0;
		cyc = 0;
		for (int i = 0; i < lim && !ok; i++) begin
			@(negedge clk);
			cyc++;
			ok = (done === 1'b1);
		end
	endtask
	// Done must stay low for n cycles; ok tells whether it did.
	task automatic quiet(input int n);
		ok = 1'b1;
		repeat (n) begin
			@(negedge clk);
			if (done !== 1'b0) ok = 1'b0;
		end
	endtask
	// Cuts a hang short well after the longest expected run.
	initial begin
		#4_000_000;
		error_cnt++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk(act === 1'b0 && done === 1'b0 && irq === 1'b0 && res === 10'h000, "reset");
		chk(mux === sacc_pkg::SRC_NONE, "reset source");
		// The bandgap buffer is taken as enabled before the bandgap row.
		foreach (rows[i]) begin
			start(rows[i].c);
			wait_done(400);
			chk(ok && (!rows[i].k || res === rows[i].r), "channel result");
		end
		start(5'h1F);
		quiet(50);
		chk(ok && act === 1'b0 && pwr === 1'b0, "channel off");
		@(posedge clk);
		cont <= 1'b1;
		start(5'h1D);
		wait_done(400);
		pulse_rd();
		@(negedge clk);
		chk(ok && done === 1'b0, "read clear");
		wait_done(400);
		chk(ok, "continuous");
		start(5'h1F);
		@(posedge clk);
		cont <= 1'b0;
		quiet(60);
		chk(ok && act === 1'b0, "continuous stop");
		start(5'h1D);
		repeat (5) @(posedge clk);
		start(5'h1E);
		@(negedge clk);
		chk(done === 1'b0 && act === 1'b1, "abort");
		wait_done(400);
		chk(ok && res === 10'h000, "restart result");
		@(posedge clk);
		cen <= 1'b1;
		cv <= 10'h050;
		start(5'h00);
		quiet(200);
		chk(ok, "compare less");
		@(posedge clk);
		gte <= 1'b1;
		start(5'h00);
		wait_done(400);
		chk(ok && res === 10'h100, "compare gte");
		@(posedge clk);
		{cen, m8, irqen, lsmp, lp} <= 5'b0_1111;
		start(5'h1D);
		@(negedge clk);
		chk(lpo === 1'b1, "low power");
		wait_done(400);
		chk(ok && res === 10'h0FF && irq === 1'b1, "8-bit and irq");
		@(posedge clk);
		{m8, irqen, lsmp, lp} <= 4'b0000;
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			src <= s[1:0];
			dv <= s[1:0];
			ws <= s[0];
			start(5'h1D);
			wait_done(3000);
			chk(ok && res === 10'h3FF, "clock source");
			// Source period in bus cycles is 1, 2, 2 or 4 here, then the divider applies.
			p = ((s == 3) ? 4 : (s == 0) ? 1 : 2) << s;
			n = (sacc_pkg::SAMPLE_SHORT + sacc_pkg::SAR_STEPS) * p;
			chk(cyc > n - p && cyc <= n + 2, "divide rate");
		end
		// Both low-voltage enables are taken as set before deep stop.
		@(posedge clk);
		{src, dv, ds} <= {sacc_pkg::CLK_ALT, 2'h0, 1'b1};
		start(5'h1D);
		quiet(200);
		chk(ok, "alt in deep stop");
		@(posedge clk);
		ds <= 1'b0;
		wait_done(3000);
		chk(ok, "alt resumes");
		// Clear the old flag, so that only the trigger can set it again.
		pulse_rd();
		@(posedge clk);
		{src, hwen, ch, trig} <= {sacc_pkg::CLK_BUS, 1'b1, 5'h1D, 1'b1};
		// The overflow pulse outlasts a conversion; it must still start only one.
		repeat (40) @(posedge clk);
		trig <= 1'b0;
		wait_done(400);
		chk(ok && res === 10'h3FF, "hw trigger");
		pulse_rd();
		quiet(100);
		chk(ok, "one start per overflow");
		// Clock enable low must freeze a conversion in flight.
		start(5'h1D);
		ce <= 1'b0;
		quiet(50);
		chk(ok && act === 1'b1 && pwr === 1'b1, "clock enable freeze");
		@(posedge clk);
		ce <= 1'b1;
		wait_done(400);
		chk(ok && res === 10'h3FF, "clock enable resume");
		// A reset in mid-conversion must bring activity, power, done flag, result and source back to rest.
		start(5'h1D);
		repeat (3) @(posedge clk);
		rst_b <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk(act === 1'b0 && done === 1'b0 && res === 10'h000 && pwr === 1'b0 &&
			mux === sacc_pkg::SRC_NONE, "mid reset");
		complete_run();
	end
endmodule // test_sacc_ctrl
`default_nettype wire
